//--- hdl/break_interval_timer.sv
`timescale 1ns/100ps
`default_nettype none
module break_interval_timer #(
  parameter int SLOW_TICK_CYCLES = break_interval_timer_pkg::TICK_SLOW_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [break_interval_timer_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [break_interval_timer_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [break_interval_timer_pkg::DATA_W-1:0] reg_rdata,
  input wire logic program_start,
  input wire logic target_running,
  input wire logic pair_one_start_match,
  input wire logic pair_one_stop_match,
  input wire logic pair_two_start_match,
  input wire logic pair_two_stop_match,
  input wire logic [break_interval_timer_pkg::SRC_N-1:0] cond_b_break_match,
  input wire logic [break_interval_timer_pkg::SRC_N-1:0] cond_b_break_set,
  input wire logic [break_interval_timer_pkg::SRC_N-1:0] cond_b_trace_match,
  input wire logic [break_interval_timer_pkg::SRC_N-1:0] cond_b_trace_set,
  input wire logic sw_break,
  input wire logic sw_seq_break,
  input wire logic hw_break,
  input wire logic hw_seq_break,
  input wire logic trace_acq_cond,
  input wire logic trace_halt_req,
  input wire logic host_mem_req,
  output logic halt_req,
  output break_interval_timer_pkg::stop_cause_t stop_cause,
  output logic trace_acq_en,
  output logic trace_halt_grant,
  output logic host_mem_refuse
);
  import break_interval_timer_pkg::*;

  initial begin
    if (SLOW_TICK_CYCLES < TICK_MID_CYCLES || SLOW_TICK_CYCLES >= (1 << DIV_W)) begin
      $error("SLOW_TICK_CYCLES out of range for the tick divider");
    end
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    interval_mode_t mode;
    tick_sel_t tick_sel;
    logic [DIV_W-1:0] div;
    pair_t p1;
    pair_t p2;
    seg_state_t seg;
    logic [RUN_W-1:0] run_total;
    logic run_ovf;
    logic halt;
    stop_cause_t cause;
    logic [DATA_W-1:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{mode: MODE_OFF, tick_sel: TICK_SLOW, div: '0,
                                   p1: PAIR_RST, p2: PAIR_RST, seg: SEG_IDLE,
                                   run_total: '0, run_ovf: 1'b0, halt: 1'b0,
                                   cause: CAUSE_NONE, rdata: '0};

  state_t state_reg;
  state_t state_next;

  // one pair of start/stop conditions; closes an interval into the statistics
  function automatic pair_t pair_step(input pair_t p, input logic start, input logic stop,
                                      input logic tick, input logic stats);
    logic [INTERVAL_W:0] sum;
    pair_t q;
    q = p;
    sum = {1'b0, p.total} + {1'b0, p.cur};
    if (p.active && stop) begin
      q.active = 1'b0;
      if (sum[INTERVAL_W] || p.cur_ovf) begin
        q.ovf = 1'b1;
      end else if (!p.ovf) begin
        q.total = sum[INTERVAL_W-1:0];
      end
      if (stats) begin
        if (p.count != '1) begin
          q.count = p.count + PASS_W'(1);
        end
        // the maximum still takes the saturated count once a single interval runs past range; the minimum cannot
        if (p.cur > p.max) begin
          q.max = p.cur;
        end
        if (p.cur < p.min) begin
          q.min = p.cur;
        end
      end
    end else if (!p.active && start) begin
      q.active = 1'b1;
      q.cur = '0;
      q.cur_ovf = 1'b0;
    end else if (p.active && tick) begin
      if (p.cur == '1) begin
        q.cur_ovf = 1'b1;
      end else begin
        q.cur = p.cur + INTERVAL_W'(1);
      end
    end
    return q;
  endfunction

  // clear at program start; an overflow raised in the same cycle survives it
  function automatic pair_t pair_clear(input pair_t nxt, input pair_t cur_p);
    pair_t q;
    q = PAIR_RST;
    q.ovf = nxt.ovf && !cur_p.ovf;
    return q;
  endfunction

  function automatic logic [INTERVAL_W-1:0] pair_avg(input pair_t p);
    logic [INTERVAL_W-1:0] a;
    a = '0;
    if (p.count != '0) begin
      a = INTERVAL_W'(p.total / INTERVAL_W'(p.count));
    end
    return a;
  endfunction

  function automatic logic [DATA_W-1:0] pair_read(input pair_t p, input logic [ADDR_W-1:0] idx);
    logic [DATA_W-1:0] d;
    d = '0;
    unique case (idx)
      TOTAL_IDX: d = DATA_W'(p.total);
      COUNT_IDX: d = DATA_W'(p.count);
      MAX_IDX: d = DATA_W'(p.max);
      MIN_IDX: d = DATA_W'(p.min);
      AVG_IDX: d = DATA_W'(pair_avg(p));
      default: d = '0;
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------
  logic measuring;
  logic pair_mode;
  logic tick;
  logic [DIV_W-1:0] div_last;
  logic [RUN_W-1:0] run_limit;
  logic [SRC_N-1:0] seg_hits;
  logic seg_hit;
  logic seg_sources_set;
  logic other_break;
  logic stats;

  always_comb begin
    measuring = state_reg.mode != MODE_OFF;
    pair_mode = measuring && state_reg.mode != MODE_FOUR;
    unique case (state_reg.tick_sel)
      TICK_MID: begin
        div_last = DIV_W'(TICK_MID_CYCLES - 1);
        run_limit = RUN_LIMIT_MID;
      end
      TICK_FAST: begin
        div_last = DIV_W'(TICK_FAST_CYCLES - 1);
        run_limit = RUN_LIMIT_FAST;
      end
      default: begin
        div_last = DIV_W'(SLOW_TICK_CYCLES - 1);
        run_limit = RUN_LIMIT_SLOW;
      end
    endcase
    tick = measuring && target_running && state_reg.div == div_last;
    seg_hits = (cond_b_break_match & cond_b_break_set) |
               (cond_b_trace_match & cond_b_trace_set);
    seg_hit = |seg_hits;
    seg_sources_set = |{cond_b_break_set, cond_b_trace_set};
    if (pair_mode) begin
      other_break = 1'b0;
    end else if (state_reg.mode == MODE_FOUR) begin
      other_break = hw_break;
    end else begin
      other_break = sw_break | sw_seq_break | hw_break | hw_seq_break;
    end
    stats = state_reg.mode == MODE_TWO || state_reg.mode == MODE_THREE;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.halt = 1'b0;

    if (measuring && target_running && !tick) begin
      state_next.div = state_reg.div + DIV_W'(1);
    end else begin
      state_next.div = '0;
    end

    if (pair_mode && target_running) begin
      state_next.p1 = pair_step(state_reg.p1, pair_one_start_match, pair_one_stop_match,
                                tick, stats);
      if (state_reg.mode == MODE_THREE) begin
        state_next.p2 = pair_step(state_reg.p2, pair_two_start_match, pair_two_stop_match,
                                  tick, 1'b1);
      end
    end

    if (state_reg.mode == MODE_ONE && state_reg.p1.active && pair_one_stop_match &&
        target_running) begin
      state_next.halt = 1'b1;
      state_next.cause = CAUSE_SEQ_U;
    end else if (other_break && target_running) begin
      state_next.halt = 1'b1;
      state_next.cause = CAUSE_OTHER;
    end

    if (state_reg.mode == MODE_FOUR && seg_sources_set && target_running) begin
      unique case (state_reg.seg)
        SEG_IDLE: begin
          if (seg_hit) begin
            state_next.seg = SEG_TIMING;
          end
        end
        SEG_TIMING: begin
          if (seg_hit) begin
            state_next.seg = SEG_IDLE;
          end
          if (tick) begin
            if (state_reg.run_total >= run_limit) begin
              state_next.run_ovf = 1'b1;
            end else begin
              state_next.run_total = state_reg.run_total + RUN_W'(1);
            end
          end
        end
        default: state_next.seg = SEG_IDLE;
      endcase
    end

    if (program_start) begin
      state_next.p1 = pair_clear(state_next.p1, state_reg.p1);
      state_next.p2 = pair_clear(state_next.p2, state_reg.p2);
      state_next.seg = SEG_IDLE;
      state_next.run_total = '0;
      // an overflow raised in this very cycle survives the clear
      state_next.run_ovf = state_next.run_ovf && !state_reg.run_ovf;
      state_next.cause = CAUSE_NONE;
      state_next.div = '0;
    end

    if (reg_wr && reg_addr == CTRL_OFS) begin
      state_next.mode = interval_mode_t'(reg_wdata[CTRL_MODE_LSB +: 3]);
      state_next.tick_sel = tick_sel_t'(reg_wdata[CTRL_TICK_LSB +: 2]);
    end

    state_next.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == CTRL_OFS) begin
        state_next.rdata = DATA_W'({state_reg.tick_sel, 1'b0, state_reg.mode});
      end else if (reg_addr == STATUS_OFS) begin
        state_next.rdata = DATA_W'({state_reg.cause, state_reg.seg == SEG_TIMING,
                                    state_reg.p2.active, state_reg.p1.active,
                                    state_reg.run_ovf, state_reg.p2.ovf, state_reg.p1.ovf});
      end else if (reg_addr >= P1_BASE_OFS && reg_addr < P2_BASE_OFS) begin
        state_next.rdata = pair_read(state_reg.p1, reg_addr - P1_BASE_OFS);
      end else if (reg_addr >= P2_BASE_OFS && reg_addr < RUN_TOTAL_OFS) begin
        state_next.rdata = pair_read(state_reg.p2, reg_addr - P2_BASE_OFS);
      end else if (reg_addr == RUN_TOTAL_OFS) begin
        state_next.rdata = state_reg.run_total[DATA_W-1:0];
      end else if (reg_addr == RUN_TOTAL_HI_OFS) begin
        state_next.rdata = DATA_W'(state_reg.run_total[RUN_W-1:DATA_W]);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    reg_rdata = state_reg.rdata;
    halt_req = state_reg.halt;
    stop_cause = state_reg.cause;
    trace_acq_en = trace_acq_cond && !measuring;
    trace_halt_grant = trace_halt_req && !measuring;
    host_mem_refuse = host_mem_req && measuring && target_running;
  end

endmodule
`default_nettype wire

//--- hdl/break_interval_timer_pkg.sv
// Contract
// - Mode 1: start on pair-one start match, halt target on later pair-one stop match.
// - Mode 1 halt reports the sequential condition-U stop cause.
// - Mode 2: keep running; sum each pair-one start-to-stop interval into a total.
// - Mode 3: also sum pair-two start-to-stop intervals into a second total, no halt.
// - The interval measurement counter is 24 bits wide.
// - Sampling tick selectable: about 52 us, 1.6 us or 20 ns.
// - Modes 2 and 3 count completed pair-one intervals as a pass count.
// - Modes 2 and 3 track pair-one maximum, minimum and average interval.
// - Mode 3 keeps total, pass count, max, min and average for pair two.
// - Accumulated time past the range sets an overflow flag instead of wrapping.
// - Max, min and average need no valid value once past the range.
// - Modes 1 to 3 ignore software, software sequential, hardware and hardware sequential breaks.
// - Any interval mode ignores trace acquisition conditions.
// - Any interval mode blocks trace-halt and refuses host memory access while running.
// - Mode 4 events come from eight condition-B break or trace sources.
// - Mode 4 timing begins at a match and ends at the next match.
// - Mode 4 alternates start and stop per match, summing segments into one total.
// - Mode 4 total range about 9999, 488 or 6 hours per tick choice.
// - Mode 4 with no condition-B source configured measures nothing.
// - Mode 4 ignores software, software sequential and hardware sequential breaks only.
`default_nettype none
package break_interval_timer_pkg;

  localparam int INTERVAL_W = 24;
  localparam int PASS_W = 16;
  localparam int RUN_W = 40;
  localparam int DIV_W = 14;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SRC_N = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real TICK_SLOW_US = 52.0;
  localparam real TICK_MID_US = 1.6;
  localparam real TICK_FAST_NS = 20.0;
  localparam int TICK_SLOW_CYCLES = int'($floor(TICK_SLOW_US * 1000.0 / CLK_PERIOD_NS));
  localparam int TICK_MID_CYCLES = int'($floor(TICK_MID_US * 1000.0 / CLK_PERIOD_NS));
  localparam int TICK_FAST_CYCLES = int'($floor(TICK_FAST_NS / CLK_PERIOD_NS));
  localparam real RUN_SLOW_HOURS = 9999.0;
  localparam real RUN_MID_HOURS = 488.0;
  localparam real RUN_FAST_HOURS = 6.0;
  localparam real US_PER_HOUR = 3600.0e6;
  localparam logic [RUN_W-1:0] RUN_LIMIT_SLOW =
    RUN_W'(longint'($floor(RUN_SLOW_HOURS * US_PER_HOUR / TICK_SLOW_US)));
  localparam logic [RUN_W-1:0] RUN_LIMIT_MID =
    RUN_W'(longint'($floor(RUN_MID_HOURS * US_PER_HOUR / TICK_MID_US)));
  localparam logic [RUN_W-1:0] RUN_LIMIT_FAST =
    RUN_W'(longint'($floor(RUN_FAST_HOURS * US_PER_HOUR * 1000.0 / TICK_FAST_NS)));

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] P1_BASE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] P2_BASE_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] RUN_TOTAL_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] RUN_TOTAL_HI_OFS = 8'h34;
  localparam logic [ADDR_W-1:0] TOTAL_IDX = 8'h00;
  localparam logic [ADDR_W-1:0] COUNT_IDX = 8'h04;
  localparam logic [ADDR_W-1:0] MAX_IDX = 8'h08;
  localparam logic [ADDR_W-1:0] MIN_IDX = 8'h0C;
  localparam logic [ADDR_W-1:0] AVG_IDX = 8'h10;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TICK_LSB = 4;
  localparam logic [2:0] CTRL_MODE_RST = 3'h0;
  localparam logic [1:0] CTRL_TICK_RST = 2'h0;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0, MODE_ONE = 3'h1, MODE_TWO = 3'h2, MODE_THREE = 3'h3, MODE_FOUR = 3'h4
  } interval_mode_t;

  typedef enum logic [1:0] {
    TICK_SLOW = 2'h0, TICK_MID = 2'h1, TICK_FAST = 2'h2
  } tick_sel_t;

  typedef enum logic [1:0] {
    CAUSE_NONE = 2'h0, CAUSE_SEQ_U = 2'h1, CAUSE_OTHER = 2'h2
  } stop_cause_t;

  typedef enum logic [1:0] {
    SEG_IDLE = 2'b01, SEG_TIMING = 2'b10
  } seg_state_t;

  typedef struct packed {
    logic active;
    logic [INTERVAL_W-1:0] cur;
    logic cur_ovf;
    logic [INTERVAL_W-1:0] total;
    logic ovf;
    logic [PASS_W-1:0] count;
    logic [INTERVAL_W-1:0] max;
    logic [INTERVAL_W-1:0] min;
  } pair_t;

  localparam pair_t PAIR_RST = '{active: 1'b0, cur: '0, cur_ovf: 1'b0, total: '0, ovf: 1'b0,
                                 count: '0, max: '0, min: '1};

endpackage
`default_nettype wire

//--- test/break_interval_timer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module break_interval_timer_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [break_interval_timer_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [break_interval_timer_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [break_interval_timer_pkg::DATA_W-1:0] reg_rdata,
  input wire logic target_running,
  input wire logic pair_one_start_match,
  input wire logic pair_one_stop_match,
  input wire logic hw_break,
  input wire logic trace_acq_cond,
  input wire logic host_mem_req,
  input wire logic halt_req,
  input wire break_interval_timer_pkg::stop_cause_t stop_cause,
  input wire logic trace_acq_en,
  input wire logic trace_halt_grant,
  input wire logic host_mem_refuse
);
  import break_interval_timer_pkg::*;
  logic [2:0] mode_q;
  logic p1_act;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // shadow of mode and pair-one interval state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 3'h0;
      p1_act <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == CTRL_OFS) begin
        mode_q <= reg_wdata[2:0];
      end
      if (target_running && mode_q inside {3'h1, 3'h2, 3'h3}) begin
        if (!p1_act && pair_one_start_match) begin
          p1_act <= 1'b1;
        end else if (p1_act && pair_one_stop_match) begin
          p1_act <= 1'b0;
        end
      end
    end
  end
  sequence p1_stop_hit;
    mode_q == 3'h1 && p1_act && target_running && pair_one_stop_match;
  endsequence
  sequence seq_halt;
    halt_req && mode_q == 3'h1;
  endsequence
  stop_halt_a: assert property (p1_stop_hit |=> halt_req)
    else $error("no halt after pair-one stop");
  halt_only_a: assert property (halt_req && mode_q inside {3'h1, 3'h2, 3'h3} |->
    mode_q == 3'h1 && $past(pair_one_stop_match)) else $error("halt without stop match");
  no_halt23_a: assert property (mode_q inside {3'h2, 3'h3} |-> !halt_req)
    else $error("halt in running mode");
  seq_cause_a: assert property (seq_halt |-> ##[0:1] stop_cause == CAUSE_SEQ_U)
    else $error("wrong stop cause");
  m4_breaks_a: assert property (halt_req && mode_q == 3'h4 |-> $past(hw_break))
    else $error("mode four halt without hardware break");
  trace_gate_a: assert property (mode_q != 3'h0 |-> !trace_acq_en)
    else $error("trace acquisition not ignored");
  trace_pass_a: assert property (mode_q == 3'h0 |-> trace_acq_en == trace_acq_cond)
    else $error("trace acquisition not passed");
  thalt_block_a: assert property (mode_q != 3'h0 |-> !trace_halt_grant)
    else $error("trace halt granted");
  mem_refuse_a: assert property (mode_q != 3'h0 && target_running && host_mem_req
    |-> host_mem_refuse) else $error("memory access not refused");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
endmodule
bind break_interval_timer break_interval_timer_monitor monitor_i (.core_clk(core_clk),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .target_running(target_running),
  .pair_one_start_match(pair_one_start_match), .pair_one_stop_match(pair_one_stop_match),
  .hw_break(hw_break), .trace_acq_cond(trace_acq_cond), .host_mem_req(host_mem_req),
  .halt_req(halt_req), .stop_cause(stop_cause), .trace_acq_en(trace_acq_en),
  .trace_halt_grant(trace_halt_grant), .host_mem_refuse(host_mem_refuse));
`default_nettype wire

//--- test/target_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module target_core_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic slow_stop,
  input wire logic halt_req,
  input wire logic [3:0] pair_ev,
  input wire logic [7:0] brk_ev,
  input wire logic [7:0] trc_ev,
  output logic target_running,
  output logic [3:0] pair_match,
  output logic [7:0] brk_match,
  output logic [7:0] trc_match
);
  logic stop_pend;
  // ----------------------------------------------------------------
  // a stopped core executes nothing, so it raises no matches
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      target_running <= 1'b0;
      stop_pend <= 1'b0;
      {pair_match, brk_match, trc_match} <= '0;
    end else begin
      {pair_match, brk_match, trc_match} <= target_running ? {pair_ev, brk_ev, trc_ev} : '0;
      stop_pend <= halt_req && slow_stop;
      if (go) begin
        target_running <= 1'b1;
      end else if ((halt_req && !slow_stop) || stop_pend) begin
        target_running <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/tb_break_interval_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_break_interval_timer;
  import break_interval_timer_pkg::*;
  logic core_clk, rst_b, reg_wr, reg_rd, program_start, go, slow_stop;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d, t, c, mx, mn, av;
  logic sw_break, sw_seq_break, hw_break, hw_seq_break, trace_acq_cond, trace_halt_req;
  logic host_mem_req, target_running, halt_req, trace_acq_en, trace_halt_grant, host_mem_refuse;
  logic [3:0] pair_ev, pm;
  logic [7:0] brk_ev, trc_ev, bm, tm, cond_b_break_set, cond_b_trace_set;
  logic [6:0] nmask;
  stop_cause_t stop_cause;
  int error_cnt = 0;
  int samples_checked = 0;
  int n, len, sum, lmax, lmin, m, b, k;

  break_interval_timer #(.SLOW_TICK_CYCLES(800)) break_interval_timer_i (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .program_start(program_start),
    .target_running(target_running), .pair_one_start_match(pm[0]),
    .pair_one_stop_match(pm[1]), .pair_two_start_match(pm[2]), .pair_two_stop_match(pm[3]),
    .cond_b_break_match(bm), .cond_b_break_set(cond_b_break_set), .cond_b_trace_match(tm),
    .cond_b_trace_set(cond_b_trace_set), .sw_break(sw_break), .sw_seq_break(sw_seq_break),
    .hw_break(hw_break), .hw_seq_break(hw_seq_break), .trace_acq_cond(trace_acq_cond),
    .trace_halt_req(trace_halt_req), .host_mem_req(host_mem_req), .halt_req(halt_req),
    .stop_cause(stop_cause), .trace_acq_en(trace_acq_en), .trace_halt_grant(trace_halt_grant),
    .host_mem_refuse(host_mem_refuse));
  target_core_model target_core_model_i (.core_clk(core_clk), .rst_b(rst_b), .go(go),
    .slow_stop(slow_stop), .halt_req(halt_req), .pair_ev(pair_ev), .brk_ev(brk_ev),
    .trc_ev(trc_ev), .target_running(target_running), .pair_match(pm), .brk_match(bm),
    .trc_match(tm));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // bus, event and check helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic pulse(input logic [3:0] p, input logic [7:0] bb, input logic [7:0] tt);
    {pair_ev, brk_ev, trc_ev} <= {p, bb, tt};
    @(posedge core_clk);
    {pair_ev, brk_ev, trc_ev} <= '0;
  endtask
  // random breaks and host requests that the active mode must ignore or refuse
  task automatic hold(input int cyc);
    repeat (cyc) begin
      {sw_break, sw_seq_break, hw_break, hw_seq_break, trace_acq_cond, trace_halt_req,
       host_mem_req} <= 7'($urandom) & nmask;
      @(posedge core_clk);
    end
    {sw_break, sw_seq_break, hw_break, hw_seq_break, trace_acq_cond, trace_halt_req,
     host_mem_req} <= 7'h0;
  endtask
  task automatic run_go();
    {program_start, go} <= 2'b11;
    @(posedge core_clk);
    {program_start, go} <= 2'b00;
    @(posedge core_clk);
  endtask
  function automatic logic near(input logic [31:0] g, input int cyc, input int dv, input int tol);
    int e;
    e = cyc / dv;
    return (^g !== 1'bx) && (int'(g) >= e - tol) && (int'(g) <= e + tol);
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, reg_wr, reg_rd, program_start, go, slow_stop, reg_addr, reg_wdata} = '0;
    {sw_break, sw_seq_break, hw_break, hw_seq_break, trace_acq_cond, trace_halt_req} = '0;
    {host_mem_req, pair_ev, brk_ev, trc_ev, cond_b_break_set, cond_b_trace_set} = '0;
    nmask = 7'h7F;
    void'($urandom(30999));
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(CTRL_OFS, d); cmp("ctrl reset", 32'h0, d);
    rd(P1_BASE_OFS + MIN_IDX, d); cmp("min reset", 32'h00FF_FFFF, d);
    rd(P1_BASE_OFS + AVG_IDX, d); cmp("avg empty", 32'h0, d);
    rd(8'h40, d); cmp("unmapped", 32'h0, d);
    wr(STATUS_OFS, 32'hFF); rd(STATUS_OFS, d); cmp("status ro", 32'h0, d);
    $display("test reset done");
    for (m = 2; m <= 3; m++) begin
      wr(CTRL_OFS, 32'h20 | m);
      run_go();
      pulse(4'h2, 8'h0, 8'h0);
      n = 2 + $urandom % 3;
      {sum, lmax, lmin} = {32'd0, 32'd0, 32'd1000};
      for (k = 0; k < n; k++) begin
        len = (k == 0) ? 2 : 10 + $urandom % 50;
        pulse((m == 3) ? 4'h5 : 4'h1, 8'h0, 8'h0);
        hold(len - 1);
        pulse((m == 3) ? 4'hA : 4'h2, 8'h0, 8'h0);
        hold(5 + $urandom % 10);
        sum += len;
        lmax = (len > lmax) ? len : lmax;
        lmin = (len < lmin) ? len : lmin;
      end
      for (b = 0; b < m - 1; b++) begin
        rd((b == 1 ? P2_BASE_OFS : P1_BASE_OFS) + COUNT_IDX, c); cmp("count", n, c);
        rd((b == 1 ? P2_BASE_OFS : P1_BASE_OFS) + TOTAL_IDX, t);
        cmp("total", 1, near(t, sum, 5, n));
        rd((b == 1 ? P2_BASE_OFS : P1_BASE_OFS) + MAX_IDX, mx);
        rd((b == 1 ? P2_BASE_OFS : P1_BASE_OFS) + MIN_IDX, mn);
        cmp("max", 1, near(mx, lmax, 5, 1));
        cmp("min", 1, near(mn, lmin, 5, 1));
        rd((b == 1 ? P2_BASE_OFS : P1_BASE_OFS) + AVG_IDX, av);
        cmp("avg", 1, near(av, sum / n, 5, 1));
      end
      $display("test mode %0d done", m);
    end
    for (m = 0; m < 2; m++) begin
      wr(CTRL_OFS, (m << 4) | 32'h2);
      run_go();
      pulse(4'h1, 8'h0, 8'h0);
      hold(2399);
      pulse(4'h2, 8'h0, 8'h0);
      hold(3);
      rd(P1_BASE_OFS + TOTAL_IDX, t);
      cmp("tick total", 1, near(t, 2400, m ? 400 : 800, 1));
    end
    $display("test tick done");
    wr(CTRL_OFS, 32'h21);
    run_go();
    slow_stop <= 1'b1;
    pulse(4'h1, 8'h0, 8'h0);
    hold(39);
    pulse(4'h2, 8'h0, 8'h0);
    for (k = 0; k < 20 && target_running; k++) @(posedge core_clk);
    cmp("target halted", 32'h0, 32'(target_running));
    if (target_running) wrap_up();
    rd(STATUS_OFS, d); cmp("stop cause", 32'(CAUSE_SEQ_U), 32'(d[7:6]));
    rd(P1_BASE_OFS + TOTAL_IDX, t); cmp("mode one total", 1, near(t, 40, 5, 1));
    $display("test mode 1 done");
    slow_stop <= 1'b0;
    nmask = 7'h6F;
    wr(CTRL_OFS, 32'h24);
    run_go();
    rd(P1_BASE_OFS + TOTAL_IDX, t); cmp("cleared", 32'h0, t);
    pulse(4'h0, 8'h08, 8'h0);
    hold(30);
    pulse(4'h0, 8'h0, 8'h20);
    hold(5);
    rd(RUN_TOTAL_OFS, d); cmp("no source", 32'h0, d);
    {cond_b_break_set, cond_b_trace_set} <= {8'h08, 8'h20};
    run_go();
    sum = 0;
    for (k = 0; k < 4; k++) begin
      len = 10 + $urandom % 40;
      pulse(4'h0, k[0] ? 8'h0 : 8'h08, k[0] ? 8'h20 : 8'h0);
      hold(len - 1);
      sum += k[0] ? 0 : len;
    end
    rd(RUN_TOTAL_OFS, d); cmp("segment sum", 1, near(d, sum, 5, 2));
    rd(RUN_TOTAL_HI_OFS, d); cmp("total high", 32'h0, d);
    // an ordinary hardware break still halts in mode 4
    hw_break <= 1'b1;
    @(posedge core_clk);
    hw_break <= 1'b0;
    repeat (3) @(posedge core_clk);
    cmp("hw break halt", 32'h0, 32'(target_running));
    rd(STATUS_OFS, d); cmp("hw cause", 32'(CAUSE_OTHER), 32'(d[7:6]));
    $display("test mode 4 done");
    wrap_up();
  end
endmodule
`default_nettype wire
